// >>> srx_phy_cfg.sv
// Summary of operation
// - bit 1 at 0x203 powers down sync buffer
// - bit 0 at 0x206 resets lane control, low
// - bit 5 enables half-rate recovery, reset one
// - bits 2:1 select oversampling division, reset zero
// - code 01 divides by two
// - code 10 divides by four
// - four-bit lane equalizer fields, zero means manual
`timescale 1ns/10ps
`default_nettype none
module srx_phy_cfg
   import srx_pkg::*;
(
   input  wire logic       clk,                           // register clock, 40 MHz
   input  wire logic       rst_n,                         // async reset, active low
   input  wire logic       spi_sclk,                      // serial clock
   input  wire logic       spi_csb,                       // chip select, active low
   input  wire logic       spi_sdi,                       // serial data in
   output var  logic       spi_sdo,                       // serial data out
   output var  logic       spi_sdo_oe,                    // serial data out enable
   output var  logic       sync_request_buffer_powerdown, // sync output buffer off
   output var  logic       recovery_logic_reset_n,        // lane control reset, low
   output var  logic       half_rate_recovery_enable,     // half-rate recovery
   output var  logic [1:0] division_rate,                 // raw division code
   output var  logic [1:0] oversample_shift,              // divide by 2**shift
   output var  logic       division_rate_reserved,        // code 11 programmed
   output var  logic [3:0] lane0_equalizer_setting,       // lane 0 boost code
   output var  logic [3:0] lane1_equalizer_setting,       // lane 1 boost code
   output var  logic       lane0_equalizer_manual,        // lane 0 manual mode
   output var  logic       lane1_equalizer_manual         // lane 1 manual mode
);
   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [7:0] sync_pd;
      logic [7:0] cdr_rst;
      logic [7:0] cdr_mode;
      logic [7:0] eq01;
      logic [1:0] ovs_shift;
      logic       div_rsvd;
      logic       eq0_man;
      logic       eq1_man;
   } srx_cfg_st_t;

   srx_cfg_st_t st_reg;
   srx_cfg_st_t st_next;
   logic [14:0] reg_addr;
   logic        reg_wr;
   logic [7:0]  reg_wdata;
   logic [7:0]  reg_rdata;

   function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] wd, input logic [7:0] m);
      merge = (old & ~m) | (wd & m);
   endfunction

   function automatic logic eq_is_manual(input logic [3:0] code);
      eq_is_manual = (code == SRX_EQ_MANUAL);
   endfunction

   // ----------------------------------------------------------------
   // serial port
   // ----------------------------------------------------------------
   srx_spi_port u_spi (
      .clk        (clk),
      .rst_n      (rst_n),
      .spi_sclk   (spi_sclk),
      .spi_csb    (spi_csb),
      .spi_sdi    (spi_sdi),
      .spi_sdo    (spi_sdo),
      .spi_sdo_oe (spi_sdo_oe),
      .reg_addr   (reg_addr),
      .reg_wr     (reg_wr),
      .reg_wdata  (reg_wdata),
      .reg_rdata  (reg_rdata)
   );

   // ----------------------------------------------------------------
   // read mux; unmapped addresses read zero
   // ----------------------------------------------------------------
   always_comb begin
      unique case (reg_addr)
         SRX_ADDR_SYNC_PD:  reg_rdata = st_reg.sync_pd & SRX_SYNC_PD_WMASK;
         SRX_ADDR_CDR_RST:  reg_rdata = st_reg.cdr_rst & SRX_CDR_RST_WMASK;
         SRX_ADDR_CDR_MODE: reg_rdata = st_reg.cdr_mode;
         SRX_ADDR_EQ_01:    reg_rdata = st_reg.eq01;
         default:           reg_rdata = 8'h00;
      endcase
   end

   // ----------------------------------------------------------------
   // register writes and decoded controls
   // ----------------------------------------------------------------
   always_comb begin
      st_next = st_reg;
      if (reg_wr) begin
         unique case (reg_addr)
            SRX_ADDR_SYNC_PD:  st_next.sync_pd = merge(st_reg.sync_pd, reg_wdata, SRX_SYNC_PD_WMASK);
            SRX_ADDR_CDR_RST:  st_next.cdr_rst = merge(st_reg.cdr_rst, reg_wdata, SRX_CDR_RST_WMASK);
            SRX_ADDR_CDR_MODE: st_next.cdr_mode = reg_wdata;
            SRX_ADDR_EQ_01:    st_next.eq01 = reg_wdata;
            default:           st_next = st_reg;
         endcase
      end
      // reserved code keeps full-rate sampling so the lanes never see a bogus ratio
      unique case (srx_div_t'(st_next.cdr_mode[SRX_DIV_LSB +: 2]))
         SRX_DIV_NONE: st_next.ovs_shift = 2'h0;
         SRX_DIV_BY2:  st_next.ovs_shift = 2'h1;
         SRX_DIV_BY4:  st_next.ovs_shift = 2'h2;
         SRX_DIV_RSVD: st_next.ovs_shift = 2'h0;
      endcase
      st_next.div_rsvd = (srx_div_t'(st_next.cdr_mode[SRX_DIV_LSB +: 2]) == SRX_DIV_RSVD);
      st_next.eq0_man  = eq_is_manual(st_next.eq01[SRX_EQ0_LSB +: 4]);
      st_next.eq1_man  = eq_is_manual(st_next.eq01[SRX_EQ1_LSB +: 4]);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg.sync_pd   <= SRX_SYNC_PD_RST;
         st_reg.cdr_rst   <= SRX_CDR_RST_RST;
         st_reg.cdr_mode  <= SRX_CDR_MODE_RST;
         st_reg.eq01      <= SRX_EQ_01_RST;
         st_reg.ovs_shift <= 2'h0;
         st_reg.div_rsvd  <= 1'b0;
         st_reg.eq0_man   <= 1'b0;
         st_reg.eq1_man   <= 1'b0;
      end else begin
         st_reg <= st_next;
      end
   end

   // ----------------------------------------------------------------
   // outputs, each a register bit or field or a registered decode
   // ----------------------------------------------------------------
   assign sync_request_buffer_powerdown = st_reg.sync_pd[SRX_PD_BIT];
   assign recovery_logic_reset_n        = st_reg.cdr_rst[SRX_CDR_RST_BIT];
   assign half_rate_recovery_enable     = st_reg.cdr_mode[SRX_HALF_RATE_BIT];
   assign division_rate                 = st_reg.cdr_mode[SRX_DIV_LSB +: 2];
   assign oversample_shift              = st_reg.ovs_shift;
   assign division_rate_reserved        = st_reg.div_rsvd;
   assign lane0_equalizer_setting       = st_reg.eq01[SRX_EQ0_LSB +: 4];
   assign lane1_equalizer_setting       = st_reg.eq01[SRX_EQ1_LSB +: 4];
   assign lane0_equalizer_manual        = st_reg.eq0_man;
   assign lane1_equalizer_manual        = st_reg.eq1_man;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   sequence s_wr_pd;
      reg_wr && reg_addr == SRX_ADDR_SYNC_PD;
   endsequence

   sequence s_wr_rst;
      reg_wr && reg_addr == SRX_ADDR_CDR_RST;
   endsequence

   sequence s_wr_mode;
      reg_wr && reg_addr == SRX_ADDR_CDR_MODE;
   endsequence

   property p_pd_follows;
      @(posedge clk) disable iff (!rst_n)
      s_wr_pd |=> sync_request_buffer_powerdown == $past(reg_wdata[SRX_PD_BIT]);
   endproperty
   a_pd_follows: assert property (p_pd_follows) else $error("sync buffer power-down missed write");

   property p_pd_holds;
      @(posedge clk) disable iff (!rst_n)
      !(reg_wr && reg_addr == SRX_ADDR_SYNC_PD) |=> $stable(sync_request_buffer_powerdown);
   endproperty
   a_pd_holds: assert property (p_pd_holds) else $error("sync buffer power-down changed unwritten");

   property p_rst_follows;
      @(posedge clk) disable iff (!rst_n)
      s_wr_rst ##1 !(reg_wr && reg_addr == SRX_ADDR_CDR_RST) [*2]
         |-> recovery_logic_reset_n == $past(reg_wdata[SRX_CDR_RST_BIT], 2);
   endproperty
   a_rst_follows: assert property (p_rst_follows) else $error("recovery reset did not track write");

   property p_half_rate;
      @(posedge clk) disable iff (!rst_n)
      s_wr_mode |=> half_rate_recovery_enable == $past(reg_wdata[SRX_HALF_RATE_BIT]);
   endproperty
   a_half_rate: assert property (p_half_rate) else $error("half-rate enable missed write");

   property p_div_field;
      @(posedge clk) disable iff (!rst_n)
      s_wr_mode |=> division_rate == $past(reg_wdata[2:1]);
   endproperty
   a_div_field: assert property (p_div_field) else $error("division field missed write");

   property p_div_by2;
      @(posedge clk) disable iff (!rst_n)
      division_rate == SRX_DIV_BY2 |-> oversample_shift == 2'h1;
   endproperty
   a_div_by2: assert property (p_div_by2) else $error("code 01 not divide by two");

   property p_div_by4;
      @(posedge clk) disable iff (!rst_n)
      division_rate == SRX_DIV_BY4 |-> oversample_shift == 2'h2;
   endproperty
   a_div_by4: assert property (p_div_by4) else $error("code 10 not divide by four");

   property p_eq_manual;
      @(posedge clk) disable iff (!rst_n)
      (lane0_equalizer_manual == (lane0_equalizer_setting == SRX_EQ_MANUAL))
         && (lane1_equalizer_manual == (lane1_equalizer_setting == SRX_EQ_MANUAL));
   endproperty
   a_eq_manual: assert property (p_eq_manual) else $error("equalizer manual flag wrong");

   property p_div_rsvd;
      @(posedge clk) disable iff (!rst_n)
      (division_rate == SRX_DIV_NONE || division_rate == SRX_DIV_RSVD)
         |-> oversample_shift == 2'h0 && division_rate_reserved == division_rate[1];
   endproperty
   a_div_rsvd: assert property (p_div_rsvd) else $error("code 00 or 11 mis-decoded");
endmodule // srx_phy_cfg
`default_nettype wire

// >>> srx_phy_cfg_tb.sv
`timescale 1ns/10ps
`default_nettype none
module srx_phy_cfg_tb;
   import srx_pkg::*;

   // ----------------------------------------------------------------
   // clock, reset and design
   // ----------------------------------------------------------------
   logic       clk = 1'b0;
   logic       rst_n = 1'b0;
   logic       spi_sclk = 1'b0;
   logic       spi_csb = 1'b1;
   logic       spi_sdi = 1'b0;
   logic       spi_sdo;
   logic       spi_sdo_oe;
   logic       sync_request_buffer_powerdown;
   logic       recovery_logic_reset_n;
   logic       half_rate_recovery_enable;
   logic [1:0] division_rate;
   logic [1:0] oversample_shift;
   logic       division_rate_reserved;
   logic [3:0] lane0_equalizer_setting;
   logic [3:0] lane1_equalizer_setting;
   logic       lane0_equalizer_manual;
   logic       lane1_equalizer_manual;
   int         n_errors = 0;
   int         cmp_count = 0;

   always #12.5 clk = ~clk;

   srx_phy_cfg u_dut (
      .clk                           (clk),
      .rst_n                         (rst_n),
      .spi_sclk                      (spi_sclk),
      .spi_csb                       (spi_csb),
      .spi_sdi                       (spi_sdi),
      .spi_sdo                       (spi_sdo),
      .spi_sdo_oe                    (spi_sdo_oe),
      .sync_request_buffer_powerdown (sync_request_buffer_powerdown),
      .recovery_logic_reset_n        (recovery_logic_reset_n),
      .half_rate_recovery_enable     (half_rate_recovery_enable),
      .division_rate                 (division_rate),
      .oversample_shift              (oversample_shift),
      .division_rate_reserved        (division_rate_reserved),
      .lane0_equalizer_setting       (lane0_equalizer_setting),
      .lane1_equalizer_setting       (lane1_equalizer_setting),
      .lane0_equalizer_manual        (lane0_equalizer_manual),
      .lane1_equalizer_manual        (lane1_equalizer_manual)
   );

   // ----------------------------------------------------------------
   // reporting
   // ----------------------------------------------------------------
   task automatic end_of_test();
      $display("compares %0d, mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic chk_bit(input logic exp, input logic act, input string what);
      cmp_count++;
      if (act !== exp) begin
         n_errors++;
         $display("unexpected at %0t: %s got %b want %b", $time, what, act, exp);
      end
   endtask

   task automatic chk_byte(input logic [7:0] exp, input logic [7:0] act, input string what);
      cmp_count++;
      if (act !== exp) begin
         n_errors++;
         $display("unexpected at %0t: %s got %h want %h", $time, what, act, exp);
      end
   endtask

   // ----------------------------------------------------------------
   // serial port frames
   // ----------------------------------------------------------------
   // sclk phases of 3 clk keep clear of the 2-period sampling minimum
   task automatic spi_xfer(input logic [23:0] frame, input int nbits, output logic [7:0] rd, output logic oe);
      rd = 8'h00;
      oe = 1'b0;
      spi_csb = 1'b0;
      repeat (2) @(negedge clk);
      for (int i = 0; i < nbits; i++) begin
         spi_sclk = 1'b0;
         spi_sdi = frame[23-i];
         repeat (3) @(negedge clk);
         if (i >= 16) begin
            rd = {rd[6:0], spi_sdo};
            oe = spi_sdo_oe;
         end
         spi_sclk = 1'b1;
         repeat (3) @(negedge clk);
      end
      spi_sclk = 1'b0;
      repeat (3) @(negedge clk);
      spi_csb = 1'b1;
      spi_sdi = ~spi_sdi;
      repeat (3) @(negedge clk);
   endtask

   task automatic wr(input logic [14:0] addr, input logic [7:0] data);
      logic [7:0] rd;
      logic       oe;
      spi_xfer({1'b0, addr, data}, 24, rd, oe);
   endtask

   task automatic rd_chk(input logic [14:0] addr, input logic [7:0] exp);
      logic [7:0] rd;
      logic       oe;
      spi_xfer({1'b1, addr, 8'h00}, 24, rd, oe);
      chk_byte(exp, rd, "read data");
      chk_bit(1'b1, oe, "sdo enable in frame");
      chk_bit(1'b0, spi_sdo_oe, "sdo enable after frame");
   endtask

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic test_reset();
      chk_bit(1'b0, sync_request_buffer_powerdown, "powerdown at reset");
      chk_bit(1'b1, recovery_logic_reset_n, "lane reset at reset");
      chk_bit(1'b1, half_rate_recovery_enable, "half rate at reset");
      chk_byte(8'h00, {6'h00, division_rate}, "division at reset");
      chk_byte(8'h88, {lane1_equalizer_setting, lane0_equalizer_setting}, "eq at reset");
      rd_chk(SRX_ADDR_SYNC_PD, 8'h00);
      rd_chk(SRX_ADDR_CDR_RST, 8'h01);
      rd_chk(SRX_ADDR_CDR_MODE, 8'h60);
      rd_chk(SRX_ADDR_EQ_01, 8'h88);
      rd_chk(15'h0204, 8'h00);
      $display("test_reset done");
   endtask

   task automatic test_sync_pd();
      wr(SRX_ADDR_SYNC_PD, 8'hFE);
      chk_bit(1'b1, sync_request_buffer_powerdown, "powerdown set");
      rd_chk(SRX_ADDR_SYNC_PD, 8'h02);
      wr(SRX_ADDR_SYNC_PD, 8'hFD);
      chk_bit(1'b0, sync_request_buffer_powerdown, "powerdown clear");
      rd_chk(SRX_ADDR_SYNC_PD, 8'h01);
      $display("test_sync_pd done");
   endtask

   task automatic test_phy_control_logic_reset();
      wr(SRX_ADDR_CDR_RST, 8'hFE);
      chk_bit(1'b0, recovery_logic_reset_n, "lane reset held");
      rd_chk(SRX_ADDR_CDR_RST, 8'h00);
      wr(SRX_ADDR_CDR_RST, 8'h01);
      chk_bit(1'b1, recovery_logic_reset_n, "lane reset released");
      $display("test_phy_control_logic_reset done");
   endtask

   task automatic test_mode();
      logic [1:0] shift_tab [4];
      logic [7:0] val;
      shift_tab = '{2'h0, 2'h1, 2'h2, 2'h0};
      for (int c = 0; c < 4; c++) begin
         val = {2'h1, c[0], 2'h0, c[1:0], 1'b0};
         wr(SRX_ADDR_CDR_MODE, val);
         chk_bit(c[0], half_rate_recovery_enable, "half rate");
         chk_byte({6'h00, c[1:0]}, {6'h00, division_rate}, "division code");
         chk_byte({6'h00, shift_tab[c]}, {6'h00, oversample_shift}, "oversample shift");
         chk_bit(c == 3, division_rate_reserved, "reserved code");
         rd_chk(SRX_ADDR_CDR_MODE, val);
      end
      $display("test_mode done");
   endtask

   task automatic test_eq();
      logic [7:0] vals [4];
      vals = '{8'h00, 8'hF1, 8'h1F, 8'h5C};
      for (int k = 0; k < 4; k++) begin
         wr(SRX_ADDR_EQ_01, vals[k]);
         chk_byte({4'h0, vals[k][3:0]}, {4'h0, lane0_equalizer_setting}, "lane0 eq");
         chk_byte({4'h0, vals[k][7:4]}, {4'h0, lane1_equalizer_setting}, "lane1 eq");
         chk_bit(vals[k][3:0] == 4'h0, lane0_equalizer_manual, "lane0 manual");
         chk_bit(vals[k][7:4] == 4'h0, lane1_equalizer_manual, "lane1 manual");
         rd_chk(SRX_ADDR_EQ_01, vals[k]);
      end
      $display("test_eq done");
   endtask

   task automatic test_abort();
      logic [7:0] rd;
      logic       oe;
      // frame cut short after 20 bits must leave the register alone
      spi_xfer({1'b0, SRX_ADDR_SYNC_PD, 8'h02}, 20, rd, oe);
      chk_bit(1'b0, sync_request_buffer_powerdown, "aborted write");
      wr(15'h0231, 8'hFF);
      rd_chk(SRX_ADDR_CDR_MODE, 8'h66);
      rd_chk(SRX_ADDR_EQ_01, 8'h5C);
      $display("test_abort done");
   endtask

   // ----------------------------------------------------------------
   // main sequence and watchdog
   // ----------------------------------------------------------------
   initial begin
      repeat (8) @(negedge clk);
      rst_n = 1'b1;
      @(negedge clk);
      test_reset();
      test_sync_pd();
      test_phy_control_logic_reset();
      test_mode();
      test_eq();
      test_abort();
      end_of_test();
   end

   // bounded run: a hang counts as a mismatch
   initial begin
      for (int n = 0; n < 90000; n++) begin
         @(posedge clk);
      end
      n_errors++;
      $display("unexpected at %0t: run limit reached", $time);
      end_of_test();
   end
endmodule // srx_phy_cfg_tb
`default_nettype wire

// >>> srx_pkg.sv
package srx_pkg;
   // ----------------------------------------------------------------
   // serial port framing
   // ----------------------------------------------------------------
   localparam int          SRX_ADDR_W      = 15;
   localparam int          SRX_DATA_W      = 8;
   localparam logic [4:0]  SRX_INSTR_BITS  = 5'h10;
   localparam logic [4:0]  SRX_FRAME_BITS  = 5'h18;
   localparam int          SRX_RW_BIT      = 15;

   // ----------------------------------------------------------------
   // register offsets
   // ----------------------------------------------------------------
   localparam logic [14:0] SRX_ADDR_SYNC_PD  = 15'h0203;
   localparam logic [14:0] SRX_ADDR_CDR_RST  = 15'h0206;
   localparam logic [14:0] SRX_ADDR_CDR_MODE = 15'h0230;
   localparam logic [14:0] SRX_ADDR_EQ_01    = 15'h0250;

   // ----------------------------------------------------------------
   // reset values and writable bits
   // ----------------------------------------------------------------
   localparam logic [7:0]  SRX_SYNC_PD_RST   = 8'h00;
   localparam logic [7:0]  SRX_CDR_RST_RST   = 8'h01;
   localparam logic [7:0]  SRX_CDR_MODE_RST  = 8'h60;
   localparam logic [7:0]  SRX_EQ_01_RST     = 8'h88;
   localparam logic [7:0]  SRX_SYNC_PD_WMASK = 8'h03;
   localparam logic [7:0]  SRX_CDR_RST_WMASK = 8'h01;
   localparam logic [7:0]  SRX_FULL_WMASK    = 8'hFF;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int          SRX_PD_BIT        = 1;
   localparam int          SRX_CDR_RST_BIT   = 0;
   localparam int          SRX_HALF_RATE_BIT = 5;
   localparam int          SRX_DIV_LSB       = 1;
   localparam int          SRX_EQ1_LSB       = 4;
   localparam int          SRX_EQ0_LSB       = 0;
   localparam logic [3:0]  SRX_EQ_MANUAL     = 4'h0;

   // ----------------------------------------------------------------
   // oversampling division codes
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      SRX_DIV_NONE = 2'b00,
      SRX_DIV_BY2  = 2'b01,
      SRX_DIV_BY4  = 2'b10,
      SRX_DIV_RSVD = 2'b11
   } srx_div_t;
endpackage

// >>> srx_spi_port.sv
`timescale 1ns/10ps
`default_nettype none
module srx_spi_port
   import srx_pkg::*;
(
   input  wire logic        clk,        // register clock
   input  wire logic        rst_n,      // async reset, active low
   input  wire logic        spi_sclk,   // serial clock, sampled
   input  wire logic        spi_csb,    // chip select, active low
   input  wire logic        spi_sdi,    // serial data in
   output var  logic        spi_sdo,    // serial data out
   output var  logic        spi_sdo_oe, // sdo driven
   output var  logic [14:0] reg_addr,   // instruction address
   output var  logic        reg_wr,     // write pulse
   output var  logic [7:0]  reg_wdata,  // write data
   input  wire logic [7:0]  reg_rdata   // read data at reg_addr
);
   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic        sclk_q;
      logic [4:0]  cnt;
      logic [15:0] instr;
      logic [7:0]  dat;
      logic [7:0]  rd_sh;
      logic        rd_loaded;
      logic        wr;
      logic        sdo;
      logic        sdo_oe;
   } srx_spi_st_t;

   srx_spi_st_t st_reg;
   srx_spi_st_t st_next;
   logic        rise;
   logic        fall;

   assign rise = spi_sclk & ~st_reg.sclk_q;
   assign fall = ~spi_sclk & st_reg.sclk_q;

   // ----------------------------------------------------------------
   // framing: 16 instruction bits then one data byte, msb first
   // ----------------------------------------------------------------
   always_comb begin
      st_next        = st_reg;
      st_next.sclk_q = spi_sclk;
      st_next.wr     = 1'b0;
      if (spi_csb) begin
         st_next.cnt       = 5'h00;
         st_next.rd_loaded = 1'b0;
         st_next.sdo       = 1'b0;
         st_next.sdo_oe    = 1'b0;
      end else begin
         if (rise && st_reg.cnt < SRX_FRAME_BITS) begin
            if (st_reg.cnt < SRX_INSTR_BITS) begin
               st_next.instr = {st_reg.instr[14:0], spi_sdi};
            end else begin
               st_next.dat = {st_reg.dat[6:0], spi_sdi};
            end
            st_next.cnt = st_reg.cnt + 5'h01;
            if (st_reg.cnt == SRX_FRAME_BITS - 5'h01 && !st_reg.instr[SRX_RW_BIT]) begin
               st_next.wr = 1'b1;
            end
         end
         // address settles one cycle before the byte is fetched
         if (st_reg.cnt == SRX_INSTR_BITS && st_reg.instr[SRX_RW_BIT] && !st_reg.rd_loaded) begin
            st_next.rd_sh     = reg_rdata;
            st_next.rd_loaded = 1'b1;
         end
         if (fall && st_reg.rd_loaded && st_reg.cnt < SRX_FRAME_BITS) begin
            st_next.sdo    = st_reg.rd_sh[7];
            st_next.rd_sh  = {st_reg.rd_sh[6:0], 1'b0};
            st_next.sdo_oe = 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign spi_sdo    = st_reg.sdo;
   assign spi_sdo_oe = st_reg.sdo_oe;
   assign reg_addr   = st_reg.instr[14:0];
   assign reg_wr     = st_reg.wr;
   assign reg_wdata  = st_reg.dat;
endmodule // srx_spi_port
`default_nettype wire
